// ---- adcc_pkg.sv ----
// Package for the converter control block: register map, field layout, reset values, codes.
// Assumes a 32-bit AXI4-Lite register bus and one 10 MHz system clock.
package adcc_pkg;
  localparam logic [3:0] ADDR_CONV_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_CONV_SETUP = 4'h4;
  localparam logic [3:0] ADDR_ANALOG_PIN_SELECT = 4'h8;
  localparam logic [3:0] ADDR_RESULT = 4'hC;
  localparam int CTL_START = 7;
  localparam int CTL_BUSY = 6;
  localparam int CTL_ENABLE = 5;
  localparam int CTL_ALIGN = 4;
  localparam logic [7:0] RESET_CONV_CONTROL = 8'h00;
  localparam logic [7:0] RESET_CONV_SETUP = 8'h00;
  localparam logic [7:0] RESET_PIN_SELECT = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [2:0] SRC_BANDGAP = 3'b001;
  localparam logic [2:0] SRC_GND_A = 3'b010;
  localparam logic [2:0] SRC_OVERCURRENT_VOLTAGE_PROTECTION = 3'b011;
  localparam logic [2:0] SRC_GND_B = 3'b100;
  localparam logic [1:0] REF_SUPPLY = 2'b01;
  localparam int RESULT_BITS = 12;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } adcc_wr_t;

  typedef struct packed {
    logic sel_external;
    logic sel_bandgap;
    logic sel_overcurrent_voltage_protection;
    logic sel_ground;
    logic [7:0] channel_onehot;
    logic ref_from_supply;
  } adcc_route_t;
endpackage : adcc_pkg

// ---- adcc_top.sv ----
// Converter control block: three control registers, result formatting, input routing,
// conversion clock divider and a start/busy handshake with the analog core.
// Assumes the analog core pulses i_core_done with i_core_result when a conversion ends.
//
// Function
// R1 - A start bit pulse 0 then 1 then 0 launches one conversion.
// R2 - Busy flag sets when a conversion starts and clears on completion.
// R3 - Align 0: result[11:4] high byte, result[3:0] in low byte upper nibble.
// R4 - Align 1: result[11:8] high byte low nibble, result[7:0] low byte.
// R5 - Result bits without conversion data read as zero.
// R6 - Result registers stay unchanged while the converter is disabled.
// R7 - Channel codes 0000-0111 route input n; top bit set selects none.
// R8 - Source codes 000 and 101-111 use the selected external channel.
// R9 - Source code 001 connects the internal bandgap reference.
// R10 - Source codes 010 and 100 tie the converter input to ground.
// R11 - Source code 011 connects the protection amplifier output.
// R12 - Software sets channel top bit whenever an internal source is chosen.
// R13 - Reference code 01 selects supply; 00 and 1x select the reference pin.
// R14 - With supply reference, software must not enable the reference pin function.
// R15 - Software sets the pin function select before using the reference pin.
// R16 - Clock divider codes give 1,2,4,8,16,32,32,128 of the system clock.
// R17 - Software keeps the conversion clock between 500 kHz and 1 MHz.
// R18 - Each pin enable bit set makes its pin an analog input.
// R19 - Six-channel variant keeps pin enables six and seven at zero.
// R20 - Enable low powers down, ignores starts, holds busy at zero.
// R21 - Completion loads the result and pulses a one-cycle completion event.
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module adcc_top
  import adcc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [31:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [31:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_core_done,
  input wire logic [RESULT_BITS-1:0] i_core_result,
  output logic o_core_start,
  output logic o_core_power_down,
  output logic o_conv_clk_en,
  output adcc_pkg::adcc_route_t o_route,
  output logic [7:0] o_analog_pin_enables,
  output logic o_conv_done
);
  import adcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [7:0] divisor_mask(input logic [2:0] code);
    // Code 110 divides by 32 like 101, as the register description prints it
    case (code)
      3'b000: divisor_mask = 8'h00;
      3'b001: divisor_mask = 8'h01;
      3'b010: divisor_mask = 8'h03;
      3'b011: divisor_mask = 8'h07;
      3'b100: divisor_mask = 8'h0F;
      3'b101: divisor_mask = 8'h1F;
      3'b110: divisor_mask = 8'h1F;
      default: divisor_mask = 8'h7F;
    endcase
  endfunction : divisor_mask

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic start_bit;
  logic busy;
  logic converter_enable;
  logic result_align_select;
  logic [3:0] external_channel_select;
  logic [7:0] conversion_setup;
  logic [7:0] analog_pin_select;
  logic [RESULT_BITS-1:0] result;
  logic [7:0] div_count;
  logic done_q;

  wire [2:0] input_source_select = conversion_setup[7:5];
  wire [1:0] reference_source_select = conversion_setup[4:3];
  wire [2:0] conv_clock_divider_select = conversion_setup[2:0];
  wire [7:0] conversion_control = {start_bit, busy, converter_enable, result_align_select,
                                   external_channel_select};

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;

  wire aw_take = i_s_axi_awvalid && o_s_axi_awready;
  wire w_take = i_s_axi_wvalid && o_s_axi_wready;
  assign o_s_axi_awready = !aw_held && !bvalid;
  assign o_s_axi_wready = !w_held && !bvalid;
  wire have_aw = aw_held || aw_take;
  wire have_w = w_held || w_take;
  wire wr_fire = have_aw && have_w && !bvalid;
  wire [3:0] wr_addr = aw_held ? aw_addr : i_s_axi_awaddr[3:0];
  wire [31:0] wr_data = w_held ? w_data : i_s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : i_s_axi_wstrb;
  wire wr_lane0 = wr_fire && wr_strb[0];
  wire wr_ctl = wr_lane0 && (wr_addr == ADDR_CONV_CONTROL);
  wire wr_setup = wr_lane0 && (wr_addr == ADDR_CONV_SETUP);
  wire wr_pins = wr_lane0 && (wr_addr == ADDR_ANALOG_PIN_SELECT);
  wire wr_known = (wr_addr == ADDR_CONV_CONTROL) || (wr_addr == ADDR_CONV_SETUP)
                  || (wr_addr == ADDR_ANALOG_PIN_SELECT) || (wr_addr == ADDR_RESULT);

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else
    begin
      if (aw_take && !wr_fire)
      begin
        aw_held <= 1'b1;
        aw_addr <= i_s_axi_awaddr[3:0];
      end
      if (w_take && !wr_fire)
      begin
        w_held <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid && i_s_axi_bready)
        bvalid <= 1'b0;
    end
  end
  assign o_s_axi_bvalid = bvalid;
  assign o_s_axi_bresp = bresp;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and conversion sequencing
  // A start is the falling edge of the start bit, so a written 1 then 0 runs once
  wire next_start_bit = wr_ctl ? wr_data[CTL_START] : start_bit;
  wire start_fall = start_bit && !next_start_bit; // R1
  wire launch = start_fall && converter_enable && !busy; // R20

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      start_bit <= RESET_CONV_CONTROL[CTL_START];
      converter_enable <= RESET_CONV_CONTROL[CTL_ENABLE];
      result_align_select <= RESET_CONV_CONTROL[CTL_ALIGN];
      external_channel_select <= RESET_CONV_CONTROL[3:0];
      conversion_setup <= RESET_CONV_SETUP;
      analog_pin_select <= RESET_PIN_SELECT;
    end
    else
    begin
      start_bit <= next_start_bit;
      if (wr_ctl)
      begin
        converter_enable <= wr_data[CTL_ENABLE];
        result_align_select <= wr_data[CTL_ALIGN];
        external_channel_select <= wr_data[3:0];
      end
      if (wr_setup)
        conversion_setup <= wr_data[7:0];
      if (wr_pins)
        analog_pin_select <= wr_data[7:0];
    end
  end

  // Completion wins over nothing else: busy only clears on done or on disable
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      busy <= 1'b0;
      result <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (!converter_enable)
        busy <= 1'b0; // R20
      else if (launch)
        busy <= 1'b1; // R2
      else if (busy && i_core_done)
      begin
        busy <= 1'b0; // R2
        result <= i_core_result; // R21 R6
        done_q <= 1'b1; // R21
      end
    end
  end

  assign o_core_start = launch; // R1
  assign o_core_power_down = !converter_enable; // R20
  assign o_conv_done = done_q;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock divider
  wire [7:0] div_mask = divisor_mask(conv_clock_divider_select); // R16
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      div_count <= 8'h00;
    else if (!converter_enable || div_count >= div_mask)
      div_count <= 8'h00;
    else
      div_count <= div_count + 8'h01;
  end
  // Enable pulse, one system cycle per conversion clock period
  assign o_conv_clk_en = converter_enable && (div_count >= div_mask); // R16

  ////////////////////////////////////////////////////////////////////////////
  // Input and reference routing, pin enables
  // Internal source with a low channel code would join signals; left to software
  wire src_external = !(input_source_select inside {SRC_BANDGAP, SRC_GND_A, SRC_OVERCURRENT_VOLTAGE_PROTECTION, SRC_GND_B});
  assign o_route.sel_external = src_external; // R8
  assign o_route.sel_bandgap = (input_source_select == SRC_BANDGAP); // R9 R12
  assign o_route.sel_overcurrent_voltage_protection = (input_source_select == SRC_OVERCURRENT_VOLTAGE_PROTECTION); // R11 R12
  assign o_route.sel_ground = (input_source_select == SRC_GND_A)
                              || (input_source_select == SRC_GND_B); // R10
  // Channel switch follows the code alone, so an internal source needs code 1xxx
  assign o_route.channel_onehot = external_channel_select[3] ? 8'h00
                                  : (8'h01 << external_channel_select[2:0]); // R7
  assign o_route.ref_from_supply = (reference_source_select == REF_SUPPLY); // R13
  assign o_analog_pin_enables = analog_pin_select; // R18

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  wire rd_take = i_s_axi_arvalid && o_s_axi_arready;
  wire [3:0] rd_addr = i_s_axi_araddr[3:0];
  wire [15:0] result_view = result_align_select
                            ? {4'h0, result} // R4 R5
                            : {result, 4'h0}; // R3 R5
  assign o_s_axi_arready = !rvalid;

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      case (rd_addr)
        ADDR_CONV_CONTROL: rdata <= {24'h00_0000, conversion_control};
        ADDR_CONV_SETUP: rdata <= {24'h00_0000, conversion_setup};
        ADDR_ANALOG_PIN_SELECT: rdata <= {24'h00_0000, analog_pin_select};
        ADDR_RESULT: rdata <= {16'h0000, result_view};
        default:
        begin
          rdata <= 32'h0000_0000;
          rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid && i_s_axi_rready)
      rvalid <= 1'b0;
  end
  assign o_s_axi_rvalid = rvalid;
  assign o_s_axi_rdata = rdata;
  assign o_s_axi_rresp = rresp;
endmodule : adcc_top
`default_nettype wire

// ---- adcc_checker.sv ----
// Port checker for the converter control block.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module adcc_checker
  import adcc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_core_done,
  input wire logic o_core_start,
  input wire logic o_core_power_down,
  input wire logic o_conv_clk_en,
  input wire adcc_pkg::adcc_route_t o_route,
  input wire logic o_conv_done
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  logic busy;
  logic fin;
  logic [8:0] gap;
  assign fin = busy && i_core_done && !o_core_power_down;
  // Busy is rebuilt from the core handshake so a stuck register shows up
  always_ff @(posedge i_mclk or posedge i_sys_rst)
    if (i_sys_rst)
      busy <= 1'b0;
    else
      busy <= !o_core_power_down && (o_core_start || (busy && !i_core_done));
  // Divider change mid-count may stretch one gap, hence the slack
  always_ff @(posedge i_mclk or posedge i_sys_rst)
    if (i_sys_rst)
      gap <= '0;
    else
      gap <= (o_conv_clk_en || o_core_power_down) ? 9'h000 : gap + 9'h001;
  sequence s_answer;
    ##1 o_conv_done ##1 !o_conv_done;
  endsequence
  ////////////////////////////////////////////////////////////
  a_launch_enabled: assert property (o_core_start |-> !o_core_power_down)
    else $error("launch while powered down");
  a_no_relaunch: assert property (busy |-> !o_core_start)
    else $error("launch while busy");
  a_done_answer: assert property (fin |-> s_answer)
    else $error("completion pulse missing or long");
  a_done_cause: assert property (!fin |=> !o_conv_done)
    else $error("completion without a finished conversion");
  a_off_no_clk: assert property (o_core_power_down |-> !o_conv_clk_en)
    else $error("conversion clock while powered down");
  a_clk_alive: assert property (gap < 9'h0FF)
    else $error("conversion clock stopped");
  a_src_onehot: assert property ($onehot({o_route.sel_external, o_route.sel_bandgap,
    o_route.sel_overcurrent_voltage_protection, o_route.sel_ground})) else $error("source select not one-hot");
  a_chan_onehot: assert property ($onehot0(o_route.channel_onehot))
    else $error("more than one channel routed");
endmodule : adcc_checker
`default_nettype wire

// ---- adcc_core_model.sv ----
// Behavioural analog core: one done pulse per launch after a set delay.
// Assumes the bench sets delay and value before each launch.
`timescale 1ns/100ps
`default_nettype none
module adcc_core_model
  import adcc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_start,
  input wire logic i_pd,
  input wire logic i_stray,
  input wire logic [7:0] i_delay,
  input wire logic [RESULT_BITS-1:0] i_value,
  output var logic o_done,
  output var logic [RESULT_BITS-1:0] o_result
);
  int cnt = 0;
  initial o_done = 1'b0;
  initial o_result = '0;
  always @(posedge i_mclk)
  begin
    // Result toggles outside done so a stale sample never matches
    o_result <= ~o_result;
    o_done <= i_stray || (cnt == 1 && !i_pd);
    if (i_stray || (cnt == 1 && !i_pd))
      o_result <= i_value;
    if (i_pd)
      cnt <= 0;
    else if (i_start)
      cnt <= i_delay + 1;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
endmodule : adcc_core_model
`default_nettype wire

// ---- adcc_top_tb.sv ----
// Self-checking bench: AXI4-Lite master tasks, random registers, conversions.
// Assumes the core model of adcc_core_model.sv on the far side.
`timescale 1ns/100ps
`default_nettype none
module adcc_top_tb;
  import adcc_pkg::*;
  logic i_mclk = '0;
  logic i_sys_rst = '1;
  logic [31:0] i_s_axi_awaddr = '0, i_s_axi_wdata = '0, i_s_axi_araddr = '0, rd;
  logic [3:0] i_s_axi_wstrb = 4'h1, c;
  logic i_s_axi_awvalid = '0, i_s_axi_wvalid = '0, i_s_axi_bready = '0, al;
  logic i_s_axi_arvalid = '0, i_s_axi_rready = '0, stray = '0;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, resp;
  logic [31:0] o_s_axi_rdata;
  logic i_core_done, o_core_start, o_core_power_down, o_conv_clk_en, o_conv_done;
  logic [RESULT_BITS-1:0] i_core_result, val = '0, v;
  logic [7:0] o_analog_pin_enables, dly = 8'h20, pins;
  adcc_route_t o_route;
  int errors = 0, num_checks = 0, starts = 0, n;
  int divs[8] = '{1, 2, 4, 8, 16, 32, 32, 128};
  always #50 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (o_core_start) starts <= starts + 1;
  adcc_top dut (.i_mclk, .i_sys_rst, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
    .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
    .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
    .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_core_done,
    .i_core_result, .o_core_start, .o_core_power_down, .o_conv_clk_en, .o_route,
    .o_analog_pin_enables, .o_conv_done);
  adcc_core_model core (.i_mclk, .i_start(o_core_start), .i_pd(o_core_power_down),
    .i_stray(stray), .i_delay(dly), .i_value(val), .o_done(i_core_done),
    .o_result(i_core_result));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic axw(input logic [3:0] a, input logic [7:0] d);
    logic pa, pw;
    {pa, pw} = 2'h3;
    i_s_axi_awaddr <= 32'(a);
    i_s_axi_wdata <= 32'(d);
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'h7;
    while (pa || pw)
    begin
      @(posedge i_mclk);
      pa = pa && !o_s_axi_awready;
      pw = pw && !o_s_axi_wready;
      i_s_axi_awvalid <= pa;
      i_s_axi_wvalid <= pw;
    end
    do @(posedge i_mclk); while (!o_s_axi_bvalid);
    resp = o_s_axi_bresp;
    i_s_axi_bready <= '0;
    @(posedge i_mclk);
  endtask : axw
  task automatic axr(input logic [3:0] a);
    i_s_axi_araddr <= 32'(a);
    {i_s_axi_arvalid, i_s_axi_rready} <= 2'h3;
    do @(posedge i_mclk); while (!o_s_axi_arready);
    i_s_axi_arvalid <= '0;
    do @(posedge i_mclk); while (!o_s_axi_rvalid);
    rd = o_s_axi_rdata;
    resp = o_s_axi_rresp;
    i_s_axi_rready <= '0;
    @(posedge i_mclk);
  endtask : axr
  function automatic logic [12:0] exp_route(input logic [2:0] s, input logic [3:0] ch);
    exp_route = {s == 3'h0 || s > 3'h4, s == 3'h1, s == 3'h3, s == 3'h2 || s == 3'h4,
      ch[3] ? 8'h00 : 8'h01 << ch[2:0], s[1:0] == 2'h1};
  endfunction : exp_route
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge i_mclk);
    errors++;
    complete_run();
  end
  initial
  begin
    void'($urandom(3494));
    repeat (5) @(posedge i_mclk);
    i_sys_rst <= '0;
    for (int k = 0; k < 4; k++)
    begin
      axr(4'(4 * k));
      chk("reset value", rd, '0);
      chk("read resp", resp, RESP_OKAY);
    end
    chk("power down", o_core_power_down, 1'b1);
    axr(4'h6);
    chk("unmapped", resp, RESP_SLVERR);
    axw(4'h6, 8'h00);
    chk("unmapped write", resp, RESP_SLVERR);
    for (int s = 0; s < 8; s++)
    begin
      c = 4'($urandom_range(0, 15));
      pins = 8'($urandom);
      if (s == 6)
        pins[7:6] = 2'b00;
      if (s == 1 || s == 3)
        c[3] = 1'b1;
      axw(ADDR_CONV_CONTROL, {4'h0, c});
      axw(ADDR_CONV_SETUP, {3'(s), 2'(s), 3'h0});
      axw(ADDR_ANALOG_PIN_SELECT, pins);
      chk("write resp", resp, RESP_OKAY);
      chk("route", o_route, exp_route(3'(s), c));
      chk("pins", o_analog_pin_enables, pins);
      axr(ADDR_CONV_SETUP);
      chk("setup", rd, {3'(s), 2'(s), 3'h0});
    end
    i_s_axi_wstrb <= 4'h0;
    axw(ADDR_ANALOG_PIN_SELECT, ~pins);
    i_s_axi_wstrb <= 4'h1;
    chk("strobe off", o_analog_pin_enables, pins);
    axw(ADDR_CONV_CONTROL, 8'h28);
    for (int d = 0; d < 8; d++)
    begin
      axw(ADDR_CONV_SETUP, 8'(d));
      repeat (2) do @(posedge i_mclk); while (!o_conv_clk_en);
      n = 0;
      do
      begin
        @(posedge i_mclk);
        n++;
      end
      while (!o_conv_clk_en);
      chk("divider", n, divs[d]);
    end
    // Divide by 16 keeps the conversion clock at 625 kHz for the runs below
    axw(ADDR_CONV_SETUP, 8'h04);
    for (int k = 0; k < 6; k++)
    begin
      al = k[0];
      val <= (k == 0) ? 12'hFFF : 12'($urandom);
      dly <= 8'($urandom_range(30, 60));
      axw(ADDR_CONV_CONTROL, {3'h5, al, 4'h8});
      axw(ADDR_CONV_CONTROL, {3'h1, al, 4'h8});
      axr(ADDR_CONV_CONTROL);
      chk("busy set", rd[CTL_BUSY], 1'b1);
      if (k == 2)
      begin
        axw(ADDR_CONV_CONTROL, {3'h5, al, 4'h8});
        axw(ADDR_CONV_CONTROL, {3'h1, al, 4'h8});
      end
      chk("launches", starts, k + 1);
      for (n = 0; n < 100 && !o_conv_done; n++) @(posedge i_mclk);
      chk("done", o_conv_done, 1'b1);
      axr(ADDR_RESULT);
      chk("result", rd, al ? 32'(val) : 32'(val) << 4);
      axw(ADDR_CONV_CONTROL, {3'h1, !al, 4'h8});
      axr(ADDR_RESULT);
      chk("realigned", rd, al ? 32'(val) << 4 : 32'(val));
      axr(ADDR_CONV_CONTROL);
      chk("busy clear", rd[CTL_BUSY], 1'b0);
    end
    v = val;
    axw(ADDR_CONV_CONTROL, 8'h08);
    val <= ~v;
    stray <= 1'b1;
    @(posedge i_mclk);
    stray <= 1'b0;
    axw(ADDR_CONV_CONTROL, 8'h88);
    axw(ADDR_CONV_CONTROL, 8'h08);
    chk("no launch off", starts, 6);
    axr(ADDR_RESULT);
    chk("result held", rd, 32'(v) << 4);
    axr(ADDR_CONV_CONTROL);
    chk("busy off", rd[CTL_BUSY], 1'b0);
    complete_run();
  end
endmodule : adcc_top_tb
bind adcc_top adcc_checker u_chk (.i_mclk, .i_sys_rst, .i_core_done, .o_core_start,
  .o_core_power_down, .o_conv_clk_en, .o_route, .o_conv_done);
`default_nettype wire
